// file: hdl/sbca_arbiter.sv
// bus control end: allocates the shared bus, supervises release, routes lines
// assumes one requester per slot on sbca_bus_if and memory/io answers on slv_*
`include "sbca_params.svh"
`default_nettype none
module sbca_arbiter #(
  parameter int TMO_CYC = `SBCA_TMO_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  sbca_bus_if.arb bus,
  output logic bus_busy,
  output sbca_pkg::sbca_src_t owner,
  output logic timeout_err,
  output logic illegal_err
);
  import sbca_pkg::*;
  typedef enum logic [1:0] {A_IDLE, A_HELD, A_TURN} sbca_arb_st_t;

  // refuse at elaboration what the logic cannot serve: the supervision count
  // must fit its counter and still leave a typical dma cycle room to finish
  if (TMO_CYC < 1 || TMO_CYC >= (1 << `SBCA_CNT_W)) begin : g_bad_tmo_range
    $error("sbca_arbiter: TMO_CYC out of range");
  end
  if (TMO_CYC <= `SBCA_DMA_CYC) begin : g_bad_tmo_short
    $error("sbca_arbiter: TMO_CYC shorter than a dma cycle");
  end
  // the priority function and the packed request vector assume three slots
  if (`SBCA_SRC_N != 3) begin : g_bad_slots
    $error("sbca_arbiter: exactly three request slots are supported");
  end

  localparam sbca_cnt_t TMO_LIM = sbca_cnt_t'(TMO_CYC);

  // lowest slot number wins: refresh, then dma, then cpu
  function automatic sbca_src_t pick(input logic [`SBCA_SRC_N-1:0] r);
    sbca_src_t s;
    s = `SBCA_SRC_CPU;
    if (r[`SBCA_SRC_DMA]) s = `SBCA_SRC_DMA;
    if (r[`SBCA_SRC_REF]) s = `SBCA_SRC_REF;
    return s;
  endfunction

  // registers and next values; the grant is kept one-hot by construction
  sbca_arb_st_t st_q, st_d;
  sbca_src_t own_q, own_d;
  sbca_cnt_t tmo_q;
  logic [`SBCA_SRC_N-1:0] gnt_q;
  sbca_word_t ad_q;
  logic is_addr_q, is_data_q;
  logic tmo_err_q, ill_q;

  // flatten the request lines and drop connections that are not allowed;
  // a dma wanting io is held off for good rather than granted
  wire req_ref = bus.req[`SBCA_SRC_REF];
  wire req_dma = bus.req[`SBCA_SRC_DMA] && !bus.is_io[`SBCA_SRC_DMA]; // RQ6
  wire req_cpu = bus.req[`SBCA_SRC_CPU];
  wire [`SBCA_SRC_N-1:0] req_ok = {req_cpu, req_dma, req_ref};
  wire any_req = |req_ok;
  wire dma_io = bus.req[`SBCA_SRC_DMA] && bus.is_io[`SBCA_SRC_DMA]; // RQ6
  wire sbca_src_t winner = pick(req_ok); // RQ2

  // holder status, looked up by the current owner
  wire own_done = bus.done[own_q];
  wire own_oe = bus.ad_oe[own_q];
  wire own_astb = bus.addr_stb[own_q];
  wire own_dstb = bus.data_stb[own_q];
  wire sbca_word_t own_ad = bus.ad_drv[own_q];

  // supervision fires when the holder keeps the bus past the limit
  wire expired = (st_q == A_HELD) && (tmo_q == TMO_LIM) && !own_done; // RQ4

  // allocation: grant only from idle, so a higher request waits for the
  // running cycle; a turnaround cycle keeps two drivers off the lines
  always_comb begin
    st_d = st_q;
    own_d = own_q;
    unique case (st_q)
      A_IDLE: begin
        if (any_req) begin // RQ1
          st_d = A_HELD;
          own_d = winner; // RQ2
        end
      end
      A_HELD: begin
        if (own_done || expired) st_d = A_TURN; // RQ3 RQ5
      end
      A_TURN: st_d = A_IDLE;
    endcase
  end

  // next values, named so that each flip-flop below only loads its own value;
  // the counter and the line copy both clear to zero in the cycle that expiry hits,
  // and the always_ff blocks stay short
  wire holding = (st_q == A_HELD) && !expired;
  wire [`SBCA_SRC_N-1:0] gnt_d = (st_d == A_HELD) ? (`SBCA_SRC_N'(1) << own_d) : '0; // RQ3 RQ5
  wire sbca_cnt_t tmo_d = holding ? tmo_q + sbca_cnt_t'(1) : '0; // RQ4
  wire busy_d = (st_d != A_IDLE);
  logic busy_q;

  // shared lines: only the holder, or the addressed module in a held cycle before expiry with the
  // holder's drivers off, reaches the bus, so each transfer is
  // one source to one destination; with nobody driving, the lines read as zero
  wire sbca_word_t line_ad = own_oe ? own_ad : (bus.slv_oe ? bus.slv_ad : '0);
  wire sbca_word_t ad_d = holding ? line_ad : '0; // RQ7 RQ9
  wire is_addr_d = holding && own_astb; // RQ8 RQ9
  wire is_data_d = holding && own_dstb && !own_astb; // RQ8

  // allocation state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= A_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // owner is kept after release so the cpu can see who held the bus last
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      own_q <= `SBCA_SRC_CPU;
    end else begin
      own_q <= own_d;
    end
  end

  // one-hot grant: rises with the held state and drops in the edge that
  // leaves it, so a forced release takes the holder off at once
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      gnt_q <= '0;
    end else begin
      gnt_q <= gnt_d;
    end
  end

  // supervision counter runs from the grant until release
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tmo_q <= '0;
    end else begin
      tmo_q <= tmo_d;
    end
  end

  // registered copy of the shared lines, one cycle behind the holder
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ad_q <= '0;
    end else begin
      ad_q <= ad_d;
    end
  end

  // phase marks travel with the copy so listeners never see them skewed
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      is_addr_q <= 1'b0;
      is_data_q <= 1'b0;
    end else begin
      is_addr_q <= is_addr_d;
      is_data_q <= is_data_d;
    end
  end

  // timeout is a one-cycle pulse per forced release, not a sticky flag, so
  // software that misses it only learns of the fault from the lost cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tmo_err_q <= 1'b0;
    end else begin
      tmo_err_q <= expired; // RQ5
    end
  end

  // the illegal flag is a level that stands while the refused request stands
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ill_q <= 1'b0;
    end else begin
      ill_q <= dma_io; // RQ6
    end
  end

  // busy is registered from the next state so the output leaves a flip-flop
  // yet still matches the state register cycle for cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
    end
  end

  // all modules see the same registered view of the lines
  for (genvar i = 0; i < `SBCA_SRC_N; i++) begin : g_gnt
    assign bus.gnt[i] = gnt_q[i];
  end
  assign bus.ad = ad_q; // RQ10
  assign bus.ad_is_addr = is_addr_q;
  assign bus.ad_is_data = is_data_q;
  // outputs leave their flip-flops directly
  assign bus_busy = busy_q;
  assign owner = own_q;
  assign timeout_err = tmo_err_q;
  assign illegal_err = ill_q;
endmodule
`default_nettype wire

// file: shared/sbca_params.svh
// constants for the system bus control arbiter and its requesters
// assumes a single 40 MHz clock shared by every end of the bus
//
// Behaviour
// RQ1: requesters ask and wait for a grant
// RQ2: fixed priority: refresh, then DMA, then CPU
// RQ3: no preemption while a bus cycle runs
// RQ4: supervise release within a time limit
// RQ5: on expiry force bus free, flag timeout
// RQ6: only CPU-memory, CPU-I/O, DMA-memory connections
// RQ7: shared 24-bit address/data lines, 16M words
// RQ8: address phase first, then data phase
// RQ9: control lines mark address/data, one-to-one connection
// RQ10: every module listens to all bus activity
// RQ11: write data follows straight after address
// RQ12: CPU holds ~450 ns, DMA ~550 ns
`ifndef SBCA_PARAMS_SVH
`define SBCA_PARAMS_SVH
`define SBCA_AD_W 24
`define SBCA_SRC_N 3
`define SBCA_SRC_REF 2'h0
`define SBCA_SRC_DMA 2'h1
`define SBCA_SRC_CPU 2'h2
`define SBCA_CLK_NS 25
`define SBCA_CPU_NS 450
`define SBCA_DMA_NS 550
`define SBCA_TMO_NS 2000
`define SBCA_CPU_CYC (`SBCA_CPU_NS / `SBCA_CLK_NS)
`define SBCA_DMA_CYC (`SBCA_DMA_NS / `SBCA_CLK_NS)
`define SBCA_TMO_CYC (`SBCA_TMO_NS / `SBCA_CLK_NS)
`define SBCA_CNT_W 8
`define SBCA_OVHD_CYC 3
`endif

// file: shared/sbca_pkg.sv
// types shared by the bus arbiter, the requesters and the bus interface
// assumes sbca_params.svh is on the include path
`include "sbca_params.svh"
`default_nettype none
package sbca_pkg;
  typedef logic [`SBCA_AD_W-1:0] sbca_word_t;
  typedef logic [1:0] sbca_src_t;
  typedef logic [`SBCA_CNT_W-1:0] sbca_cnt_t;
endpackage
`default_nettype wire

// file: shared/sbca_bus_if.sv
// shared backplane bus: per-source request and drive lines, one granted view
// assumes the bench drives the memory/io answer lines slv_oe and slv_ad
`include "sbca_params.svh"
`default_nettype none
interface sbca_bus_if;
  import sbca_pkg::*;
  // per-source lines, one element per requester
  logic req [`SBCA_SRC_N];
  logic is_io [`SBCA_SRC_N];
  logic done [`SBCA_SRC_N];
  logic ad_oe [`SBCA_SRC_N];
  sbca_word_t ad_drv [`SBCA_SRC_N];
  logic addr_stb [`SBCA_SRC_N];
  logic data_stb [`SBCA_SRC_N];
  // arbiter side
  logic gnt [`SBCA_SRC_N];
  sbca_word_t ad;
  logic ad_is_addr;
  logic ad_is_data;
  // answer from the addressed memory or io module
  logic slv_oe;
  sbca_word_t slv_ad;
  modport arb (input req, input is_io, input done, input ad_oe, input ad_drv, input addr_stb,
    input data_stb, input slv_oe, input slv_ad, output gnt, output ad, output ad_is_addr,
    output ad_is_data);
  modport usr (output req, output is_io, output done, output ad_oe, output ad_drv,
    output addr_stb, output data_stb, input gnt, input ad, input ad_is_addr, input ad_is_data);
endinterface
`default_nettype wire

// file: hdl/sbca_requester.sv
// one bus user (cpu, dma or refresh end): request, address phase, data phase
// assumes the arbiter end on the other side of sbca_bus_if; SRC picks the slot
`include "sbca_params.svh"
`default_nettype none
module sbca_requester #(
  parameter sbca_pkg::sbca_src_t SRC = `SBCA_SRC_CPU
) (
  input wire logic clk,
  input wire logic reset_n,
  sbca_bus_if.usr bus,
  input wire logic start,
  input wire logic is_io,
  input wire logic write,
  input wire sbca_pkg::sbca_word_t addr,
  input wire sbca_pkg::sbca_word_t wdata,
  output logic busy,
  output logic done,
  output logic aborted,
  output sbca_pkg::sbca_word_t rdata
);
  import sbca_pkg::*;
  typedef enum logic [2:0] {S_IDLE, S_REQ, S_ADDR, S_DATA, S_END} sbca_rq_st_t;
  localparam int HOLD = (SRC == `SBCA_SRC_DMA) ? `SBCA_DMA_CYC : `SBCA_CPU_CYC;
  localparam sbca_cnt_t DATA_CYC = sbca_cnt_t'(HOLD - `SBCA_OVHD_CYC);
  // refuse at elaboration a slot code past the last one, or a hold too short to
  // leave a data cycle after the overhead or too long for the cycle counter
  if (SRC > `SBCA_SRC_CPU || HOLD <= `SBCA_OVHD_CYC ||
      HOLD - `SBCA_OVHD_CYC >= (1 << `SBCA_CNT_W)) begin : g_bad_cfg
    $error("sbca_requester: bad SRC or hold");
  end
  sbca_rq_st_t st_q, st_d;
  sbca_cnt_t cnt_q;
  sbca_word_t addr_q, wdata_q;
  logic io_q, wr_q, done_q, abort_q, busy_q;
  sbca_word_t rdata_q;
  wire granted = bus.gnt[SRC];
  // losing the grant mid-cycle means the arbiter timed us out
  wire lost = (st_q == S_ADDR || st_q == S_DATA) && !granted;
  wire last_data = (st_q == S_DATA) && (cnt_q == '0);
  // sequence: wait for grant, one address cycle, then data cycles
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      S_IDLE: if (start) st_d = S_REQ;
      S_REQ: if (granted) st_d = S_ADDR; // RQ1
      S_ADDR: st_d = lost ? S_IDLE : S_DATA; // RQ8
      S_DATA: st_d = lost ? S_IDLE : (last_data ? S_END : S_DATA);
      S_END: st_d = S_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= S_IDLE;
      cnt_q <= '0;
      addr_q <= '0;
      wdata_q <= '0;
      io_q <= 1'b0;
      wr_q <= 1'b0;
      done_q <= 1'b0;
      abort_q <= 1'b0;
      busy_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      st_q <= st_d;
      done_q <= (st_d == S_END);
      abort_q <= lost;
      busy_q <= (st_d != S_IDLE); // same timing as the state register
      if (st_q == S_IDLE && start) begin
        addr_q <= addr;
        wdata_q <= wdata;
        io_q <= is_io && (SRC == `SBCA_SRC_CPU); // RQ6
        wr_q <= write && (SRC != `SBCA_SRC_REF);
      end
      // hold time sets how long the bus stays occupied
      cnt_q <= (st_d == S_DATA && st_q != S_DATA) ? DATA_CYC : cnt_q - sbca_cnt_t'(st_q == S_DATA); // RQ12
      if (last_data && !lost) rdata_q <= bus.ad; // RQ10
    end
  end
  // bus drive lines follow the state register directly
  assign bus.req[SRC] = (st_q == S_REQ) || (st_q == S_ADDR) || (st_q == S_DATA);
  assign bus.is_io[SRC] = io_q;
  assign bus.done[SRC] = (st_q == S_END);
  assign bus.addr_stb[SRC] = (st_q == S_ADDR); // RQ9
  assign bus.data_stb[SRC] = (st_q == S_DATA); // RQ9
  assign bus.ad_oe[SRC] = (st_q == S_ADDR) || (st_q == S_DATA && wr_q); // RQ11
  assign bus.ad_drv[SRC] = (st_q == S_ADDR) ? addr_q : wdata_q; // RQ7
  assign busy = busy_q;
  assign done = done_q;
  assign aborted = abort_q;
  assign rdata = rdata_q;
endmodule
`default_nettype wire

// file: tb/sbca_props.sv
// checker: grant order, release and phase marking on the shared bus
// assumes one clock; the bus signals are wired in by name
`include "sbca_params.svh"
`default_nettype none
module sbca_props #(
  parameter int TMO_CYC = `SBCA_TMO_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic req [`SBCA_SRC_N],
  input wire logic is_io [`SBCA_SRC_N],
  input wire logic done [`SBCA_SRC_N],
  input wire logic gnt [`SBCA_SRC_N],
  input wire logic ad_is_addr,
  input wire logic ad_is_data
);
  logic [2:0] g, d, g_q, r_q, ng;
  logic io_q;
  logic [7:0] held_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // packed views, so one-hot and priority tests stay short
  assign g = {gnt[2], gnt[1], gnt[0]};
  assign d = {done[2], done[1], done[0]};
  assign ng = g & ~g_q;
  // last-cycle copies; held_q counts cycles under a grant
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      g_q <= 3'h0;
      r_q <= 3'h0;
      io_q <= 1'b0;
      held_q <= 8'h00;
    end else begin
      g_q <= g;
      r_q <= {req[2], req[1], req[0]};
      io_q <= is_io[1];
      held_q <= (g != 3'h0) ? held_q + 8'h01 : 8'h00;
    end
  end
  a_one_holder: assert property ($onehot0(g)) else $error("two grants");
  a_grant_has_req: assert property (ng != 3'h0 |-> (ng & r_q) == ng) else $error("grant without request");
  a_ref_over_dma: assert property (ng[1] |-> !r_q[0]) else $error("dma beat refresh");
  a_dma_over_cpu: assert property (ng[2] |-> !r_q[0] && !(r_q[1] && !io_q)) else $error("cpu beat higher");
  a_no_preempt: assert property (g != 3'h0 |=> g == $past(g) || g == 3'h0) else $error("grant switched");
  a_turn_gap: assert property (g_q != 3'h0 && g == 3'h0 |=> g == 3'h0) else $error("no idle gap");
  a_done_frees: assert property ((d & g) != 3'h0 |=> g == 3'h0) else $error("bus kept after done");
  a_hold_bounded: assert property (held_q <= TMO_CYC + 2) else $error("grant held too long");
  a_dma_no_io: assert property (ng[1] |-> !io_q) else $error("dma joined to io");
  a_phase_excl: assert property (!(ad_is_addr && ad_is_data)) else $error("both phases marked");
  a_data_follows: assert property (ad_is_addr |=> ad_is_data) else $error("no data after address");
  a_addr_first: assert property ($rose(ad_is_data) |-> $past(ad_is_addr)) else $error("data first");
  c_refresh: cover property (ng[0]);
  c_dma: cover property (ng[1]);
  c_cycle: cover property (ad_is_addr ##1 ad_is_data);
endmodule
`default_nettype wire

// file: tb/test_system_bus_control_arbiter.sv
// bench: three users and the arbiter on one bus, a bare arbiter on a second
// assumes 40 MHz; on the second bus the bench itself misbehaves on purpose
`include "sbca_params.svh"
`default_nettype none
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin failures++; $display("CHECK FAILED %s expected %h seen %h", nm, e, s); end end
module test_system_bus_control_arbiter;
  timeunit 1ns;
  timeprecision 100ps;
  import sbca_pkg::*;
  localparam int T2 = 30;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic start [3] = '{default: 1'b0};
  logic io [3] = '{default: 1'b0};
  logic wr [3] = '{default: 1'b0};
  sbca_word_t addr [3] = '{default: 24'h0};
  sbca_word_t wdata [3] = '{default: 24'h0};
  logic done [3];
  sbca_word_t rdata [3];
  logic tmo2, ill2;
  sbca_src_t own;
  sbca_word_t last_a, last_d;
  int failures = 0;
  int n_checks = 0;
  int order [$];
  sbca_bus_if bus ();
  sbca_bus_if bus2 ();
  // one user per slot: refresh, dma, cpu
  for (genvar k = 0; k < 3; k++) begin : g_usr
    sbca_requester #(.SRC(sbca_src_t'(k))) sbca_requester_i (.clk(clk), .reset_n(reset_n), .bus(bus.usr),
      .start(start[k]), .is_io(io[k]), .write(wr[k]), .addr(addr[k]), .wdata(wdata[k]), .busy(),
      .done(done[k]), .aborted(), .rdata(rdata[k]));
  end
  sbca_arbiter #(.TMO_CYC(T2)) sbca_arbiter_i (.clk(clk), .reset_n(reset_n), .bus(bus.arb), .bus_busy(),
    .owner(own), .timeout_err(), .illegal_err());
  // second arbiter: the bench holds the bus and asks for a refused path
  if (1) begin : g_fault
    sbca_arbiter #(.TMO_CYC(T2)) sbca_arbiter_i (.clk(clk), .reset_n(reset_n), .bus(bus2.arb), .bus_busy(),
      .owner(), .timeout_err(tmo2), .illegal_err(ill2));
  end
  sbca_props #(.TMO_CYC(T2)) sbca_props_i (.clk(clk), .reset_n(reset_n), .req(bus.req), .is_io(bus.is_io),
    .done(bus.done), .gnt(bus.gnt), .ad_is_addr(bus.ad_is_addr), .ad_is_data(bus.ad_is_data));
  initial forever #12.5 clk = ~clk;
  // grant order and what each phase carried
  always @(posedge clk) begin
    if ($rose(bus.gnt[0])) order.push_back(0);
    if ($rose(bus.gnt[1])) order.push_back(1);
    if ($rose(bus.gnt[2])) order.push_back(2);
    if (bus.ad_is_addr) last_a <= bus.ad;
    if (bus.ad_is_data) last_d <= bus.ad;
  end
  task automatic go(input int k, input logic i, input logic w, input sbca_word_t a, input sbca_word_t dv);
    @(posedge clk);
    start[k] <= 1'b1;
    io[k] <= i;
    wr[k] <= w;
    addr[k] <= a;
    wdata[k] <= dv;
    @(posedge clk);
    start[k] <= 1'b0;
  endtask
  // bounded wait; done is a one-cycle pulse, so look every cycle
  task automatic wait_done(input int k);
    int n;
    n = 0;
    while (done[k] !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    `CHK("done", 1'b1, done[k])
  endtask
  task automatic t_write_read();
    go(2, 1'b0, 1'b1, 24'habc123, 24'h5a5a01);
    wait_done(2);
    `CHK("addr", 24'habc123, last_a)
    `CHK("wdata", 24'h5a5a01, last_d)
    `CHK("owner", 2'h2, own)
    @(posedge clk);
    bus.slv_oe <= 1'b1;
    bus.slv_ad <= 24'h3c3c3c;
    go(2, 1'b1, 1'b0, 24'hfffffe, 24'h0);
    wait_done(2);
    `CHK("raddr", 24'hfffffe, last_a)
    `CHK("rdata", 24'h3c3c3c, rdata[2])
    @(posedge clk);
    bus.slv_oe <= 1'b0;
    $display("test write_read done");
  endtask
  task automatic t_priority();
    order.delete();
    @(posedge clk);
    for (int k = 0; k < 3; k++) begin
      start[k] <= 1'b1;
      io[k] <= 1'b0;
      addr[k] <= 24'h000100 + 24'(k);
    end
    @(posedge clk);
    for (int k = 0; k < 3; k++) start[k] <= 1'b0;
    wait_done(2);
    `CHK("grants", 3, order.size())
    `CHK("first", 0, order[0])
    `CHK("second", 1, order[1])
    $display("test priority done");
  endtask
  task automatic t_no_preempt();
    order.delete();
    go(2, 1'b0, 1'b1, 24'h000042, 24'h000007);
    repeat (4) @(posedge clk);
    go(0, 1'b0, 1'b0, 24'h000000, 24'h0);
    wait_done(0);
    `CHK("held", 2, order[0])
    `CHK("next", 0, order[1])
    $display("test no_preempt done");
  endtask
  task automatic t_faults();
    int n;
    n = 0;
    @(posedge clk);
    bus2.req[2] <= 1'b1;
    while (bus2.gnt[2] !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (bus2.gnt[2] === 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    `CHK("tmo", 1'b1, tmo2)
    `CHK("span", 1'b1, n >= T2 && n <= T2 + 2)
    @(posedge clk);
    bus2.req[2] <= 1'b0;
    bus2.req[1] <= 1'b1;
    bus2.is_io[1] <= 1'b1;
    repeat (6) @(negedge clk);
    `CHK("illegal", 1'b1, ill2)
    `CHK("dma_gnt", 1'b0, bus2.gnt[1])
    $display("test faults done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    bus.slv_oe = 1'b0;
    bus.slv_ad = 24'h0;
    bus2.slv_oe = 1'b0;
    bus2.slv_ad = 24'h0;
    bus2.req = '{default: 1'b0};
    bus2.is_io = '{default: 1'b0};
    bus2.done = '{default: 1'b0};
    bus2.ad_oe = '{default: 1'b0};
    bus2.ad_drv = '{default: 24'h0};
    bus2.addr_stb = '{default: 1'b0};
    bus2.data_stb = '{default: 1'b0};
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_write_read();
    t_priority();
    t_no_preempt();
    t_faults();
    close_out();
  end
  // tests need about 200 cycles; a hang is cut well beyond that
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    close_out();
  end
endmodule
`default_nettype wire
